/* File: design/nesp_defines.vh */
`ifndef NESP_DEFINES_VH
`define NESP_DEFINES_VH

// Register byte offsets
`define NESP_OFF_RES0 8'h00
`define NESP_OFF_CTRL 8'h20
`define NESP_OFF_STAT 8'h24
`define NESP_OFF_REF0 8'h40
`define NESP_RES_SPAN 8'h1c

// Result register fields
`define NESP_PAR_HI 23
`define NESP_PAR_LO 12
`define NESP_WORD_HI 11
`define NESP_WORD_LO 3
`define NESP_BIT_HI 2
`define NESP_BIT_LO 0

// Reference register fields
`define NESP_REF_PAR 12

// Control register fields and page size codes
`define NESP_CTRL_SIZE_HI 1
`define NESP_CTRL_SIZE_LO 0
`define NESP_SIZE_512 2'h0
`define NESP_SIZE_2048 2'h1
`define NESP_SIZE_4096 2'h2
`define NESP_LAST_512 12'h1ff
`define NESP_LAST_2048 12'h7ff
`define NESP_LAST_4096 12'hfff

// Status register fields
`define NESP_STAT_ERR_LO 0
`define NESP_STAT_MUL_LO 8
`define NESP_STAT_OPAR_LO 16
`define NESP_STAT_DONE 24
`define NESP_STAT_BUSY 25

// Byte counter split: sector, then byte within sector
`define NESP_SEC_HI 11
`define NESP_SEC_LO 9

`endif

/* File: design/nesp_sector_acc.v */
`timescale 1ns/1ps
module nesp_sector_acc #(
  parameter WORD_W = 9
)(
  clk,
  rstn,
  clr,
  en,
  word_idx,
  data,
  check_bits,
  odd_par
);
  input wire clk;
  input wire rstn;
  input wire clr;
  input wire en;
  input wire [WORD_W-1:0] word_idx;
  input wire [7:0] data;
  output reg [WORD_W+2:0] check_bits;
  output reg odd_par;

  ////////////////////////////////////////////////////////////////////////////
  // Xor of the bit offsets of all ones in a byte
  function [2:0] bit_xor;
    input [7:0] d;
    integer i;
    begin
      bit_xor = 3'h0;
      for (i = 0; i < 8; i = i + 1)
      begin
        if (d[i])
          bit_xor = bit_xor ^ i[2:0];
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // The code is the xor of {word, bit} over every one bit of the sector,
  // so a single flipped bit shows up as its own location in the syndrome.
  wire byte_odd = ^data;
  wire [WORD_W+2:0] contrib = {(byte_odd ? word_idx : {WORD_W{1'b0}}),
                               bit_xor(data)};

  always @(posedge clk)
  begin
    if (!rstn || clr)
    begin
      check_bits <= {(WORD_W+3){1'b0}};
      odd_par <= 1'b0;
    end
    else if (en)
    begin
      check_bits <= check_bits ^ contrib;
      odd_par <= odd_par ^ byte_odd;
    end
  end

endmodule

/* File: design/nesp_top.v */
// Overview of operation
// - Result register 0 covers page bytes 0 through 511.
// - Result register 1 covers page bytes 512 through 1023.
// - Result register 2 covers the third sector, ending at byte 1535.
// - Result register 3 covers page bytes 1536 through 2047.
// - Result register 4 covers bytes 2048 to 2559, larger pages only.
// - Result register 5 covers page bytes 2560 through 3071.
// - Result register 6 covers page bytes 3072 through 3583.
// - After a read with one error, the bit offset of the bad bit.
// - After a read with one error, the sector-relative byte index.
// - With several errors, offset and index are meaningless to software.
`timescale 1ns/1ps
`include "nesp_defines.vh"
module nesp_top #(
  parameter SECTORS = 7,
  parameter WORD_W = 9
)(
  clk,
  rstn,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  page_start,
  page_is_read,
  byte_valid,
  byte_data,
  page_done
);
  input wire clk;
  input wire rstn;
  input wire [7:0] reg_addr;
  input wire [31:0] reg_wdata;
  input wire reg_wr;
  input wire reg_rd;
  output reg [31:0] reg_rdata;
  input wire page_start;
  input wire page_is_read;
  input wire byte_valid;
  input wire [7:0] byte_data;
  output reg page_done;

  localparam CHK_W = WORD_W + 3;
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN = 2'h1;
  localparam ST_LATCH = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Control state
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [11:0] cnt_r;
  reg [1:0] size_r;
  reg [1:0] cfg_size_r;
  reg read_mode_r;
  reg [23:0] result_r [0:SECTORS-1];
  reg [CHK_W:0] ref_r [0:SECTORS-1];
  reg [SECTORS-1:0] err_r;
  reg [SECTORS-1:0] mul_r;
  reg [SECTORS-1:0] opar_r;
  wire [CHK_W*SECTORS-1:0] acc_chk;
  wire [SECTORS-1:0] acc_par;
  wire [SECTORS-1:0] acc_en;
  wire [CHK_W*SECTORS-1:0] syn_w;
  wire [SECTORS-1:0] syn_nz_w;
  wire [SECTORS-1:0] pmis_w;
  wire [SECTORS-1:0] live_w;
  wire [11:0] last_w;
  integer s;
  integer t;

  ////////////////////////////////////////////////////////////////////////////
  // Last byte of the page for a size code
  function [11:0] last_byte;
    input [1:0] sz;
    begin
      case (sz)
        `NESP_SIZE_512: last_byte = `NESP_LAST_512;
        `NESP_SIZE_2048: last_byte = `NESP_LAST_2048;
        default: last_byte = `NESP_LAST_4096;
      endcase
    end
  endfunction

  // Index of a register inside a block of word-spaced registers
  function [2:0] reg_index;
    input [7:0] a;
    input [7:0] base;
    reg [7:0] d;
    begin
      d = a - base;
      reg_index = d[4:2];
    end
  endfunction

  // True when the address hits a block of SECTORS words at base
  function in_block;
    input [7:0] a;
    input [7:0] base;
    reg [7:0] d;
    begin
      d = a - base;
      in_block = (a >= base) && (d < `NESP_RES_SPAN) && (d[1:0] == 2'h0);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Per-sector accumulators
  assign last_w = last_byte(size_r);
  genvar g;
  generate
    for (g = 0; g < SECTORS; g = g + 1)
    begin : sec
      assign acc_en[g] = (state_r == ST_RUN) && byte_valid &&
                         (cnt_r[`NESP_SEC_HI:`NESP_SEC_LO] == g);
      nesp_sector_acc #(
        .WORD_W(WORD_W)
      ) u_acc (
        .clk(clk),
        .rstn(rstn),
        .clr(page_start),
        .en(acc_en[g]),
        .word_idx(cnt_r[WORD_W-1:0]),
        .data(byte_data),
        .check_bits(acc_chk[g*CHK_W +: CHK_W]),
        .odd_par(acc_par[g])
      );
      // Syndrome against the stored check word
      assign syn_w[g*CHK_W +: CHK_W] = acc_chk[g*CHK_W +: CHK_W] ^
                                       ref_r[g][CHK_W-1:0];
      assign syn_nz_w[g] = |syn_w[g*CHK_W +: CHK_W];
      assign pmis_w[g] = acc_par[g] ^ ref_r[g][`NESP_REF_PAR];
      // sectors beyond the page stay clear
      assign live_w[g] = (last_w[`NESP_SEC_HI:`NESP_SEC_LO] >= g);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Page sequencing: the snapshot waits one cycle so the last byte lands
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (page_start)
          state_nxt = ST_RUN;
      ST_RUN:
        if (page_start)
          state_nxt = ST_RUN;
        else if (byte_valid && cnt_r == last_byte(size_r))
          state_nxt = ST_LATCH;
      ST_LATCH:
        state_nxt = page_start ? ST_RUN : ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge clk)
  begin
    if (!rstn)
    begin
      state_r <= ST_IDLE;
      cnt_r <= 12'h000;
      size_r <= `NESP_SIZE_512;
      read_mode_r <= 1'b0;
      page_done <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      if (page_start)
      begin
        cnt_r <= 12'h000;
        size_r <= cfg_size_r;
        read_mode_r <= page_is_read;
      end
      else if (state_r == ST_RUN && byte_valid)
        cnt_r <= cnt_r + 12'h001;
      // Completion wins over a new page started in the same cycle
      if (state_r == ST_LATCH)
        page_done <= 1'b1;
      else if (page_start)
        page_done <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result snapshot at the end of a page
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      for (s = 0; s < SECTORS; s = s + 1)
        result_r[s] <= 24'h000000;
      err_r <= {SECTORS{1'b0}};
      mul_r <= {SECTORS{1'b0}};
      opar_r <= {SECTORS{1'b0}};
    end
    else if (state_r == ST_LATCH)
    begin
      opar_r <= live_w & acc_par;
      for (s = 0; s < SECTORS; s = s + 1)
      begin
        if (!live_w[s])
        begin
          result_r[s] <= 24'h000000;
          err_r[s] <= 1'b0;
          mul_r[s] <= 1'b0;
        end
        else if (read_mode_r)
        begin
          result_r[s] <= {acc_chk[s*CHK_W +: CHK_W],
                          syn_w[s*CHK_W +: CHK_W]};
          err_r[s] <= syn_nz_w[s] | pmis_w[s];
          // even parity with nonzero syndrome means several errors
          mul_r[s] <= syn_nz_w[s] & ~pmis_w[s];
        end
        else
        begin
          // check bits left for the host to save
          result_r[s] <= {acc_chk[s*CHK_W +: CHK_W], {CHK_W{1'b0}}};
          err_r[s] <= 1'b0;
          mul_r[s] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes: control and the stored check words for a page read
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      cfg_size_r <= `NESP_SIZE_512;
      for (t = 0; t < SECTORS; t = t + 1)
        ref_r[t] <= {(CHK_W+1){1'b0}};
    end
    else if (reg_wr)
    begin
      if (reg_addr == `NESP_OFF_CTRL)
        cfg_size_r <= reg_wdata[`NESP_CTRL_SIZE_HI:`NESP_CTRL_SIZE_LO];
      else if (in_block(reg_addr, `NESP_OFF_REF0))
        ref_r[reg_index(reg_addr, `NESP_OFF_REF0)] <= reg_wdata[CHK_W:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads, answered one cycle after the strobe
  always @(posedge clk)
  begin
    if (!rstn)
      reg_rdata <= 32'h00000000;
    else if (reg_rd)
    begin
      reg_rdata <= 32'h00000000;
      if (in_block(reg_addr, `NESP_OFF_RES0))
        reg_rdata <= {8'h00, result_r[reg_index(reg_addr, `NESP_OFF_RES0)]};
      else if (in_block(reg_addr, `NESP_OFF_REF0))
        reg_rdata <= {{(31-CHK_W){1'b0}},
                      ref_r[reg_index(reg_addr, `NESP_OFF_REF0)]};
      else if (reg_addr == `NESP_OFF_CTRL)
        reg_rdata <= {30'h00000000, cfg_size_r};
      else if (reg_addr == `NESP_OFF_STAT)
      begin
        reg_rdata[`NESP_STAT_ERR_LO +: SECTORS] <= err_r;
        reg_rdata[`NESP_STAT_MUL_LO +: SECTORS] <= mul_r;
        reg_rdata[`NESP_STAT_OPAR_LO +: SECTORS] <= opar_r;
        reg_rdata[`NESP_STAT_DONE] <= page_done;
        reg_rdata[`NESP_STAT_BUSY] <= (state_r != ST_IDLE);
      end
    end
  end

endmodule

/* File: sim/nesp_flash_model.sv */
`timescale 1ns/1ps
module nesp_flash_model (
  input wire clk,
  input wire go,
  input wire slow,
  input wire [12:0] len,
  input wire [11:0] err_pos,
  input wire [7:0] err_mask,
  output reg page_start = 1'b0,
  output reg byte_valid = 1'b0,
  output reg [7:0] byte_data = 8'h00
);
  reg [12:0] k_r = 13'h0;
  reg busy_r = 1'b0;
  reg gap_r = 1'b0;
  function [7:0] pat(input [11:0] k);
    pat = k[7:0] * 8'h1d ^ k[11:4];
  endfunction
  ////////////////////////////////////////
  always @(posedge clk)
  begin
    page_start <= go;
    byte_valid <= 0;
    // Released lines toggle so a stale byte never passes as data
    byte_data <= ~byte_data;
    gap_r <= slow & ~gap_r;
    if (go)
    begin
      busy_r <= 1;
      k_r <= 0;
    end
    else if (busy_r && !gap_r)
    begin
      byte_valid <= 1;
      byte_data <= pat(k_r[11:0]) ^ (k_r[11:0] == err_pos ? err_mask : 0);
      k_r <= k_r + 1;
      busy_r <= k_r + 1 < len;
    end
  end
endmodule

/* File: sim/nesp_top_checker.sv */
`timescale 1ns/1ps
module nesp_top_checker (
  input wire clk,
  input wire rstn,
  input wire [7:0] reg_addr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire page_start,
  input wire page_is_read,
  input wire byte_valid,
  input wire page_done
);
  reg md_r;
  wire rr = reg_rd && reg_addr < 8'h1c;
  // Kind of the last page, so write results can be told apart
  always @(posedge clk)
    if (page_start)
      md_r <= page_is_read;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////
  top_zero_a: assert property (rr |=> reg_rdata[31:24] == 0)
    else $error("top byte");
  write_low_a: assert property (rr && page_done && !md_r
    && !page_start |=> reg_rdata[11:0] == 0) else $error("write low");
  unmapped_zero_a: assert property (reg_rd && (reg_addr == 8'h1c
    || reg_addr > 8'h58) |=> reg_rdata == 0) else $error("unmapped");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("rdata moved");
  done_clear_a: assert property (page_start && page_done
    |=> !page_done [*3]) else $error("done early");
  done_hold_a: assert property (page_done && !page_start
    |=> page_done) else $error("done dropped");
  done_late_a: assert property ($rose(page_done)
    |-> $past(byte_valid, 2)) else $error("done timing");
  status_done_a: assert property (reg_rd && reg_addr == 8'h24
    |=> reg_rdata[24] == $past(page_done)) else $error("status done");
  cover property (page_start && page_is_read);
  cover property ($rose(page_done));
  cover property (rr && page_done);
endmodule
bind nesp_top nesp_top_checker u_chk (.clk, .rstn, .reg_addr, .reg_rd,
  .reg_rdata, .page_start, .page_is_read, .byte_valid, .page_done);

/* File: sim/nesp_top_tb.sv */
`timescale 1ns/1ps
module nesp_top_tb;
  reg clk, rstn, reg_wr, reg_rd, go, slow, page_is_read;
  reg [7:0] reg_addr, err_mask, v;
  reg [31:0] reg_wdata, d;
  reg [12:0] len;
  reg [11:0] err_pos, e, f, ck [0:6];
  reg pr [0:6];
  integer bad_count, check_count, cyc, s, j, b, n;
  wire [31:0] reg_rdata;
  wire page_start, byte_valid, page_done;
  wire [7:0] byte_data;
  nesp_top u_nesp_top (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .page_start, .page_is_read, .byte_valid,
    .byte_data, .page_done);
  nesp_flash_model u_nesp_flash_model (.clk, .go, .slow, .len, .err_pos,
    .err_mask, .page_start, .byte_valid, .byte_data);
  initial
  begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
    if (++cyc == 60000)
    begin
      bad_count++;
      end_of_test;
    end
  task end_of_test;
  begin
    if (bad_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
  begin
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  end
  endtask
  ////////////////////////////////////////
  task wr(input [7:0] a, input [31:0] x);
  begin
    @(posedge clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= x;
    @(posedge clk);
    reg_wr <= 0;
  end
  endtask
  task rd(input [7:0] a);
  begin
    @(posedge clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 0;
    #1 d = reg_rdata;
  end
  endtask
  task page(input m, input [12:0] l, input [11:0] p, input [7:0] x);
  begin
    @(posedge clk);
    go <= 1;
    page_is_read <= m;
    len <= l;
    err_pos <= p;
    err_mask <= x;
    @(posedge clk);
    go <= 0;
    // Old done only clears once the start pulse has landed
    repeat (2) @(posedge clk);
    for (j = 0; j < 9000 && page_done !== 1; j++)
      @(posedge clk);
    chk(page_done, 1);
  end
  endtask
  task t_regs;
  begin
    wr(0, 32'hffffffff);
    for (s = 0; s < 9; s++)
    begin
      rd(s * 4);
      chk(d, 0);
    end
    rd(8'h70);
    chk(d, 0);
  end
  endtask
  task t_write;
  begin
    for (b = 0; b < 3; b++)
    begin
      wr(8'h20, b);
      n = b * 3 + 1;
      page(0, n == 7 ? 4096 : n * 512, 0, 0);
      for (s = 0; s < 7; s++)
      begin
        rd(s * 4);
        chk(d, s < n ? {ck[s], 12'h0} : 0);
      end
    end
    // host keeps each result in the spare area
    for (s = 0; s < 7; s++)
      wr(8'h40 + s * 4, {pr[s], ck[s]});
  end
  endtask
  task t_single;
  begin
    for (n = 0; n < 7; n++)
    begin
      e = {n[0] ? 9'h1ff : 9'h0, n[2:0]};
      page(1, 4096, n * 512 + e[11:3], 8'h1 << n);
      for (s = 0; s < 7; s++)
      begin
        f = s == n ? e : 12'h0;
        rd(s * 4);
        chk(d, {ck[s] ^ f, f});
      end
      rd(8'h24);
      chk({d[14:8], d[6:0]}, 1 << n);
    end
  end
  endtask
  task t_multi;
  begin
    wr(8'h40, {pr[0], ck[0] ^ 12'h3});
    slow <= 1;
    page(1, 4096, 0, 0);
    slow <= 0;
    rd(8'h24);
    chk(d[8], 1);
    for (s = 0; s < 7; s++)
      v[s] = pr[s];
    chk(d, {8'h01, 1'b0, v[6:0], 16'h0101});
  end
  endtask
  initial
  begin
    {rstn, reg_wr, reg_rd, go, slow, page_is_read} = 0;
    {reg_addr, reg_wdata, len, err_pos, err_mask} = 0;
    {bad_count, check_count, cyc} = 0;
    for (s = 0; s < 7; s++)
    begin
      ck[s] = 0;
      pr[s] = 0;
      // Index j is byte and bit together, the term each one bit adds
      for (j = 0; j < 4096; j++)
      begin
        v = u_nesp_flash_model.pat(s * 512 + j / 8);
        if (v[j % 8])
        begin
          ck[s] = ck[s] ^ j[11:0];
          pr[s] = ~pr[s];
        end
      end
    end
    repeat (8) @(posedge clk);
    rstn <= 1;
    t_regs;
    t_write;
    t_single;
    t_multi;
    end_of_test;
  end
endmodule
